/* File: adcc_top.sv */
// converter control: apb registers, clock select, conversion sequencer
// assumes an analog sar core that steps on bit ticks and returns its result
`timescale 1ns/10ps
module adcc_top import adcc_pkg::*; (
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              RC_CLK,
  input  wire logic [RES_W-1:0]  SAR_RESULT,
  output logic      [CHN_W-1:0]  CHANNEL_SEL,
  output logic      [1:0]        REF_SEL,
  output logic                   CONV_ENABLE,
  output logic                   SAR_START,
  output logic                   SAR_BIT_TICK,
  output logic                   CONV_BUSY,
  output logic      [NPIN-1:0]   DIG_IN_EN,
  output logic      [NPIN-1:0]   PIN_DIR
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [DIV_W-1:0] clk_div(input logic [2:0] sel);
    logic [2:0] idx;
    idx = {sel[1:0], sel[2]};
    clk_div = DIV_BASE << idx;
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    if (a == ADDR_CTRL0) begin
      addr_ok = 1'b1;
    end else if (a == ADDR_CTRL1) begin
      addr_ok = 1'b1;
    end else if (a == ADDR_RESULT) begin
      addr_ok = 1'b1;
    end else if (a == ADDR_ASEL) begin
      addr_ok = 1'b1;
    end else if (a == ADDR_DIR) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  endfunction

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_q;
  logic       rst_b_s;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_b_s = rst_q[1];

  // ****************************************
  // state
  // ****************************************
  adcc_regs_t       r;
  adcc_regs_t       n;
  logic             sys_tick;
  logic             rc_tick;
  logic             bit_tick;
  logic             access;
  logic             wr_now;
  logic [31:0]      rd_word;
  logic [1:0]       wref;

  always_comb begin
    n         = r;
    n.start_p = 1'b0;
    n.tick_p  = 1'b0;

    // rc pin synchroniser and edge
    n.rc_sync = {r.rc_sync[0], RC_CLK};
    n.rc_prev = r.rc_sync[1];
    rc_tick   = r.rc_sync[1] & ~r.rc_prev;

    // result bus synchroniser
    n.res_s1  = SAR_RESULT;
    n.res_s2  = r.res_s1;

    // system clock divider
    if (r.div_cnt >= clk_div(r.cks) - DIV_W'(1)) begin
      n.div_cnt = '0;
      sys_tick  = 1'b1;
    end else begin
      n.div_cnt = r.div_cnt + DIV_W'(1);
      sys_tick  = 1'b0;
    end

    // one tick per bit period
    if (r.cks[1:0] == CKS_RC) begin
      bit_tick = rc_tick;
    end else begin
      bit_tick = sys_tick;
    end

    // conversion sequencer
    case (r.state)
      ST_IDLE: begin
        if (r.go && r.on) begin
          n.state = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (bit_tick) begin
          n.state   = ST_CONV;
          n.bit_cnt = '0;
          n.start_p = 1'b1;
          n.busy    = 1'b1;
        end
      end
      ST_CONV: begin
        if (bit_tick) begin
          n.tick_p  = 1'b1;
          n.bit_cnt = r.bit_cnt + 4'h1;
          if (r.bit_cnt == BIT_PERIODS - 4'h1) begin
            n.state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        n.result = r.res_s2;
        n.go     = 1'b0;
        n.busy   = 1'b0;
        n.state  = ST_IDLE;
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase

    // turning the converter off aborts
    if (!r.on && (r.state != ST_IDLE)) begin
      n.state = ST_IDLE;
      n.go    = 1'b0;
      n.busy  = 1'b0;
    end

    // apb read data
    if (PADDR == ADDR_CTRL0) begin
      rd_word = 32'(r.chn) << CTRL0_CHN;
      rd_word[CTRL0_GO] = r.go;
      rd_word[CTRL0_ON] = r.on;
    end else if (PADDR == ADDR_CTRL1) begin
      rd_word = (32'(r.cks) << CTRL1_CKS) | (32'(r.refsel) << CTRL1_REF);
    end else if (PADDR == ADDR_RESULT) begin
      rd_word = 32'(r.result);
      rd_word[RESULT_BUSY] = r.busy;
    end else if (PADDR == ADDR_ASEL) begin
      rd_word = 32'(r.asel);
    end else if (PADDR == ADDR_DIR) begin
      rd_word = 32'(r.dir);
    end else begin
      rd_word = 32'h0000_0000;
    end

    // apb handshake: one wait state
    access = PSEL && PENABLE;
    wr_now = access && r.pready && PWRITE && !r.pslverr;
    if (access && !r.pready) begin
      n.pready  = 1'b1;
      n.pslverr = !addr_ok(PADDR);
      n.prdata  = PWRITE ? 32'h0000_0000 : rd_word;
    end else begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      n.prdata  = 32'h0000_0000;
    end

    // register writes take effect on the completing edge
    wref = PWDATA[CTRL1_REF +: 2];
    if (wr_now) begin
      if (PADDR == ADDR_CTRL0) begin
        n.chn = PWDATA[CTRL0_CHN +: CHN_W];
        n.on  = PWDATA[CTRL0_ON];
        if (!PWDATA[CTRL0_ON]) begin
          n.go = 1'b0;
        end else if (PWDATA[CTRL0_GO] && (r.state == ST_IDLE) && !r.go) begin
          n.go = 1'b1;
        end
      end else if (PADDR == ADDR_CTRL1) begin
        n.cks    = PWDATA[CTRL1_CKS +: 3];
        n.refsel = (wref == REF_RSVD) ? REF_SUPPLY : wref;
      end else if (PADDR == ADDR_ASEL) begin
        n.asel   = PWDATA[NPIN-1:0];
        n.dig_en = ~PWDATA[NPIN-1:0];
      end else if (PADDR == ADDR_DIR) begin
        n.dir = PWDATA[NPIN-1:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_b_s) begin
    if (!rst_b_s) begin
      r        <= '0;
      r.asel   <= ASEL_RST;
      r.dig_en <= ~ASEL_RST;
      r.dir    <= DIR_RST;
      r.state  <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign PRDATA       = r.prdata;
  assign PREADY       = r.pready;
  assign PSLVERR      = r.pslverr;
  assign CHANNEL_SEL  = r.chn;
  assign REF_SEL      = r.refsel;
  assign CONV_ENABLE  = r.on;
  assign SAR_START    = r.start_p;
  assign SAR_BIT_TICK = r.tick_p;
  assign CONV_BUSY    = r.busy;
  assign DIG_IN_EN    = r.dig_en;
  assign PIN_DIR      = r.dir;

endmodule

/* File: adcc_pkg.sv */
// constants, types and field layout of the converter control block
// assumes one 10 MHz system clock and an APB master with 32-bit data
//
// Operation
// - channel_select picks the analog input fed to sample-and-hold.
// - positive_ref_select picks supply, external or fixed reference; negative is ground.
// - conversion_clock_select: 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64, x11 rc.
// - one selected conversion clock period is one bit_conversion_period.
// - a full 8-bit conversion lasts exactly ten bit_conversion_periods.
// - divided clocks follow the system clock; the rc clock stays independent.
// - the rc clock gives a bit_conversion_period near 1.6 us, 1.0 to 6.0 us.
// - a set analog_select bit turns off that pin's digital input buffer.
package adcc_pkg;

  // ****************************************
  // bus map
  // ****************************************
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] ADDR_CTRL0  = 12'h000;
  localparam logic [11:0] ADDR_CTRL1  = 12'h004;
  localparam logic [11:0] ADDR_RESULT = 12'h008;
  localparam logic [11:0] ADDR_ASEL   = 12'h00c;
  localparam logic [11:0] ADDR_DIR    = 12'h010;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int          CHN_W       = 4;
  localparam int          NPIN        = 16;
  localparam int          RES_W       = 8;
  localparam int          CTRL0_ON    = 0;
  localparam int          CTRL0_GO    = 1;
  localparam int          CTRL0_CHN   = 2;
  localparam int          CTRL1_REF   = 0;
  localparam int          CTRL1_CKS   = 4;
  localparam int          RESULT_BUSY = 8;
  localparam logic [15:0] ASEL_RST    = 16'hffff;
  localparam logic [15:0] DIR_RST     = 16'hffff;

  // reference choices
  localparam logic [1:0]  REF_SUPPLY  = 2'h0;
  localparam logic [1:0]  REF_EXT     = 2'h1;
  localparam logic [1:0]  REF_FIXED   = 2'h2;
  localparam logic [1:0]  REF_RSVD    = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int          DIV_W       = 7;
  localparam logic [6:0]  DIV_BASE    = 7'h02;
  localparam logic [1:0]  CKS_RC      = 2'h3;
  localparam logic [3:0]  BIT_PERIODS = 4'ha;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_CONV = 2'b11,
    ST_DONE = 2'b10
  } adcc_state_t;

  typedef struct packed {
    logic [1:0]       rc_sync;
    logic             rc_prev;
    logic [RES_W-1:0] res_s1;
    logic [RES_W-1:0] res_s2;
    logic [RES_W-1:0] result;
    logic [CHN_W-1:0] chn;
    logic             go;
    logic             on;
    logic [2:0]       cks;
    logic [1:0]       refsel;
    logic [NPIN-1:0]  asel;
    logic [NPIN-1:0]  dig_en;
    logic [NPIN-1:0]  dir;
    logic [DIV_W-1:0] div_cnt;
    logic [3:0]       bit_cnt;
    adcc_state_t      state;
    logic             start_p;
    logic             tick_p;
    logic             busy;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } adcc_regs_t;

endpackage

/* File: adcc_chk.sv */
// checker: register fields to pins, tick spacing, conversion length
// assumes a bind to adcc_top, sees its ports only
`timescale 1ns/10ps
module adcc_chk import adcc_pkg::*; (
  input wire logic              CLK,
  input wire logic              RST_B,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic              PREADY,
  input wire logic [CHN_W-1:0]  CHANNEL_SEL,
  input wire logic [1:0]        REF_SEL,
  input wire logic              CONV_ENABLE,
  input wire logic              SAR_START,
  input wire logic              SAR_BIT_TICK,
  input wire logic              CONV_BUSY,
  input wire logic [NPIN-1:0]   DIG_IN_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic       wr;
  logic [2:0] cks;
  logic [6:0] gap;
  logic [6:0] div;
  logic [3:0] nt;
  assign wr  = PSEL && PENABLE && PREADY && PWRITE;
  assign div = DIV_BASE << ({1'b0, cks[1:0], 1'b0} + {3'h0, cks[2]});
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cks <= 3'h0;
      gap <= 7'h00;
      nt  <= 4'h0;
    end else begin
      if (wr && PADDR == ADDR_CTRL1) begin
        cks <= PWDATA[6:4];
      end
      gap <= (SAR_START || SAR_BIT_TICK) ? 7'h01 : gap + 7'h01;
      nt  <= SAR_START ? 4'h0 : nt + {3'h0, SAR_BIT_TICK};
    end
  end
  a_chan_route: assert property (
    wr && PADDR == ADDR_CTRL0 |-> ##2 CHANNEL_SEL == $past(PWDATA[5:2], 2))
    else $error("channel mismatch");
  a_ref_route: assert property (
    wr && PADDR == ADDR_CTRL1 && PWDATA[1:0] != REF_RSVD |-> ##2 REF_SEL == $past(PWDATA[1:0], 2))
    else $error("reference mismatch");
  a_div_period: assert property (
    SAR_BIT_TICK && !SAR_START && CONV_BUSY && cks[1:0] != CKS_RC |-> gap == div)
    else $error("divided period wrong");
  a_rc_period: assert property (
    SAR_BIT_TICK && !SAR_START && CONV_BUSY && cks[1:0] == CKS_RC |-> gap >= 10 && gap <= 60)
    else $error("rc period out of span");
  a_ten_ticks: assert property (
    $fell(CONV_BUSY) && CONV_ENABLE |-> nt == BIT_PERIODS)
    else $error("tick count wrong");
  a_go_start: assert property (
    wr && PADDR == ADDR_CTRL0 && PWDATA[1:0] == 2'h3 && !CONV_BUSY |-> ##[1:80] SAR_START)
    else $error("no start");
  a_off_abort: assert property (
    $fell(CONV_ENABLE) |-> ##[0:2] !CONV_BUSY)
    else $error("no abort");
  a_dig_off: assert property (
    wr && PADDR == ADDR_ASEL |-> ##2 DIG_IN_EN == ~$past(PWDATA[15:0], 2))
    else $error("input buffer mismatch");
endmodule
bind adcc_top adcc_chk u_chk (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PREADY, .CHANNEL_SEL, .REF_SEL, .CONV_ENABLE, .SAR_START, .SAR_BIT_TICK, .CONV_BUSY,
  .DIG_IN_EN);

/* File: adcc_sar_model.sv */
// analog core stand-in: free rc oscillator, result code
// assumes the result is sampled only when a conversion ends
`timescale 1ns/10ps
module adcc_sar_model import adcc_pkg::*; (
  output logic                  rc_clk,
  output logic      [RES_W-1:0] result,
  input  wire logic [CHN_W-1:0] chan,
  input  wire logic [1:0]       refsel,
  input  wire logic             en
);
  initial rc_clk = 1'b0;
  always #803 rc_clk = ~rc_clk;
  // code names input and reference; inverted while off
  assign result = en ? {chan, 2'h2, refsel} : ~{chan, 2'h2, refsel};
endmodule

/* File: tb_adc_config_and_clock_select.sv */
// bench: apb scenarios on the converter control block
// assumes adcc_top, the core model and the checker
`timescale 1ns/10ps
module tb_adc_config_and_clock_select import adcc_pkg::*;;
  logic              CLK = 1'b0;
  logic              RST_B = 1'b0;
  logic              PSEL = 1'b0;
  logic              PENABLE = 1'b0;
  logic              PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = '0;
  logic [31:0]       PWDATA = '0;
  logic [31:0]       PRDATA, rd;
  logic              PREADY, PSLVERR, RC_CLK, SAR_START, SAR_BIT_TICK, CONV_BUSY, CONV_ENABLE, er;
  logic [7:0]        SAR_RESULT, last;
  logic [3:0]        CHANNEL_SEL;
  logic [1:0]        REF_SEL;
  logic [15:0]       DIG_IN_EN, PIN_DIR;
  int                num_errors = 0;
  int                checks = 0;
  localparam int     ACQ_CYCLES = 20;  // acquisition wait, plain default
  always #50 CLK = ~CLK;
  adcc_top dut (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .RC_CLK, .SAR_RESULT, .CHANNEL_SEL, .REF_SEL, .CONV_ENABLE, .SAR_START,
    .SAR_BIT_TICK, .CONV_BUSY, .DIG_IN_EN, .PIN_DIR);
  adcc_sar_model u_sar (.rc_clk(RC_CLK), .result(SAR_RESULT), .chan(CHANNEL_SEL),
    .refsel(REF_SEL), .en(CONV_ENABLE));
  task end_of_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask
  task wt(input int n);
    if (n > 2000) begin
      num_errors++;
      end_of_test;
    end
    @(negedge CLK);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n = n + 1;
      if (n > 2000) begin
        num_errors++;
        end_of_test;
      end
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task wbusy(input logic v);
    int n;
    n = 0;
    while (CONV_BUSY !== v) begin
      wt(n);
      n = n + 1;
    end
  endtask
  task t_pins;
    chk("dig rst", 32'h0, {16'h0, DIG_IN_EN});
    apb(1'b0, ADDR_ASEL, 32'h0);
    chk("asel", 32'hffff, rd);
    apb(1'b0, ADDR_DIR, 32'h0);
    chk("dir", 32'hffff, rd);
    apb(1'b1, ADDR_ASEL, 32'h00a5);
    apb(1'b1, ADDR_DIR, 32'h0f0f);
    repeat (2) @(negedge CLK);
    chk("dig", 32'hff5a, {16'h0, DIG_IN_EN});
    chk("pdir", 32'h0f0f, {16'h0, PIN_DIR});
    $display("t_pins done");
  endtask
  task t_conv;
    logic [2:0] cs [8];
    logic [3:0] ch;
    logic [1:0] rf;
    cs = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7}; // model has no minimum
    apb(1'b1, ADDR_ASEL, 32'hffff);
    apb(1'b1, ADDR_DIR, 32'hffff);
    for (int i = 0; i < 8; i++) begin
      ch = 4'(2 * i + 1);
      rf = 2'(i % 3);
      apb(1'b1, ADDR_CTRL1, {25'h0, cs[i], 2'h0, rf});
      apb(1'b1, ADDR_CTRL0, {26'h0, ch, 2'h1});
      repeat (ACQ_CYCLES) @(posedge CLK);
      apb(1'b1, ADDR_CTRL0, {26'h0, ch, 2'h3});
      wbusy(1'b1);
      wbusy(1'b0);
      last = {ch, 2'h2, rf};
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk("result", {24'h0, last}, rd);
      apb(1'b0, ADDR_CTRL0, 32'h0);
      chk("ctrl0", {26'h0, ch, 2'h1}, rd);
    end
    $display("t_conv done");
  endtask
  task t_abort;
    apb(1'b1, ADDR_CTRL0, 32'h15);
    repeat (ACQ_CYCLES) @(posedge CLK);
    apb(1'b1, ADDR_CTRL0, 32'h17);
    wbusy(1'b1);
    repeat (40) @(negedge CLK);
    apb(1'b1, ADDR_CTRL0, 32'h14);
    wbusy(1'b0);
    chk("enable", 32'h0, {31'h0, CONV_ENABLE});
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("kept", {24'h0, last}, rd);
    $display("t_abort done");
  endtask
  task t_bad;
    apb(1'b1, 12'h014, 32'hff);
    chk("werr", 32'h1, {31'h0, er});
    apb(1'b0, 12'h014, 32'h0);
    chk("rerr", 32'h1, {31'h0, er});
    chk("rdat", 32'h0, rd);
    apb(1'b1, ADDR_RESULT, 32'hff);
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("ro", {24'h0, last}, rd);
    apb(1'b1, ADDR_CTRL1, 32'h73);
    apb(1'b0, ADDR_CTRL1, 32'h0);
    chk("ref3", 32'h70, rd);
    $display("t_bad done");
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK);
    t_pins;
    t_conv;
    t_abort;
    t_bad;
    end_of_test;
  end
endmodule
